// >>> user_gate_array_pkg.sv
// Shared constants, types and helpers for the user gate array
`default_nettype none
package user_gate_array_pkg;

   // Pin space: 0..99 field inputs, 100..199 field outputs, 200+ links
   localparam int PIN_W = 8;
   localparam int NUM_PINS = 256;
   localparam int IN_PINS = 100;
   localparam int OUT_PIN_BASE = 100;
   localparam int LINK_PIN_BASE = 200;
   localparam int PORT_DIGITS = 10;

   // Array shape
   localparam int CELLS_PER_KIND = 4;
   localparam int NUM_KINDS = 6;
   localparam int NUM_CELLS = CELLS_PER_KIND * NUM_KINDS;
   localparam int IDX_W = 5;
   localparam int LATCH_BASE = 12;
   localparam int TIMER_BASE = 20;
   localparam int CNT_W = 8;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_PERIOD_NS = 100_000_000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_SEC = 10;
   localparam int TENTH_W = 4;

   // Reset values
   localparam logic LATCH_RESET_STATE = 1'b1;

   // Timer type codes
   localparam logic [7:0] TT_DELAY_TENTH = 8'h01;
   localparam logic [7:0] TT_EXT_TENTH = 8'h02;
   localparam logic [7:0] TT_SHOT_TENTH = 8'h03;
   localparam logic [7:0] TT_DELAY_SEC = 8'h10;
   localparam logic [7:0] TT_EXT_SEC = 8'h20;
   localparam logic [7:0] TT_SHOT_SEC = 8'h30;

   typedef enum logic [2:0] {
      K_AND, K_OR, K_XOR, K_LATCH, K_RELAY, K_TIMER
   } cell_kind_e;

   // Four pin or setting fields per cell, meaning depends on kind
   typedef struct packed {
      logic [PIN_W-1:0] a;
      logic [PIN_W-1:0] b;
      logic [PIN_W-1:0] c;
      logic [PIN_W-1:0] d;
   } cell_cfg_s;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic lock;
   } tmr_st_s;

   // Logic pin of a port and bit position
   function automatic logic [PIN_W-1:0] pin_number(input int port,
                                                   input int bitpos);
      pin_number = PIN_W'((port - 1) * PORT_DIGITS + bitpos);
   endfunction

endpackage
`default_nettype wire

// >>> cell_eval.sv
// One evaluation step of any cell kind, shared by all cells
`timescale 1ns/1ps
`default_nettype none
module cell_eval
   import user_gate_array_pkg::*;
(
   input wire cell_kind_e kind_i,
   input wire logic va_i,
   input wire logic vb_i,
   input wire logic latch_q_i,
   input wire tmr_st_s tmr_i,
   input wire logic [7:0] ttype_i,
   input wire logic [CNT_W-1:0] ttime_i,
   input wire logic sec_i,
   output logic o1_o,
   output logic o2_o,
   output logic latch_d_o,
   output tmr_st_s tmr_d_o
);

   logic dec;
   logic zero;
   logic [CNT_W-1:0] dn;

   // Whole-second types only step on the second boundary
   assign dec = (ttype_i[7:4] == 4'h0) || sec_i;
   assign zero = (tmr_i.cnt == '0);
   assign dn = (dec && !zero) ? tmr_i.cnt - CNT_W'(1) : tmr_i.cnt;

   // Kind dispatch
   always_comb begin
      o1_o = 1'b0;
      o2_o = 1'b1;
      latch_d_o = latch_q_i;
      tmr_d_o = tmr_i;
      unique case (kind_i)
         K_AND: begin
            o1_o = va_i & vb_i;
            o2_o = ~o1_o;
         end
         K_OR: begin
            o1_o = va_i | vb_i;
            o2_o = ~o1_o;
         end
         K_XOR: begin
            o1_o = va_i ^ vb_i;
            o2_o = ~o1_o;
         end
         K_LATCH: begin
            if (vb_i) begin
               latch_d_o = 1'b0;
            end else if (va_i) begin
               latch_d_o = 1'b1;
            end
            o1_o = latch_d_o;
            o2_o = ~latch_d_o;
         end
         K_RELAY: begin
            o1_o = vb_i ? 1'b0 : va_i;
            o2_o = vb_i ? va_i : 1'b0;
         end
         K_TIMER: begin
            o2_o = 1'b0;
            unique case (ttype_i)
               TT_DELAY_TENTH, TT_DELAY_SEC: begin
                  o1_o = va_i && zero;
                  tmr_d_o.cnt = va_i ? dn : ttime_i;
               end
               TT_EXT_TENTH, TT_EXT_SEC: begin
                  o1_o = va_i || !zero;
                  tmr_d_o.cnt = va_i ? ttime_i : dn;
               end
               TT_SHOT_TENTH, TT_SHOT_SEC: begin
                  if (!va_i) begin
                     tmr_d_o.cnt = ttime_i;
                     tmr_d_o.lock = 1'b0;
                  end else if (!tmr_i.lock) begin
                     o1_o = !zero;
                     tmr_d_o.cnt = dn;
                     tmr_d_o.lock = zero;
                  end
               end
               // Unknown codes pass the input unchanged
               default: begin
                  o1_o = va_i;
               end
            endcase
         end
         default: begin
            o1_o = 1'b0;
         end
      endcase
   end

endmodule // cell_eval
`default_nettype wire

// >>> user_gate_array.sv
// User gate array: sequential sweep of 24 logic cells once per tick
//
// Notes on behaviour
// - OR output high if any input high; second output is its inverse.
// - XOR output high when inputs differ; second output is its inverse.
// - Latch starts set: true output one, complement zero.
// - Latch samples set and reset once per tenth-second tick only.
// - Reset high, alone or with set, clears the latch.
// - Set alone high sets the latch.
// - Latch outputs are always opposite.
// - Relay with coil low routes common to rest contact.
// - Relay samples coil each tick; coil high routes to work contact.
// - Timer type code selects function and tenth or whole-second base.
// - Timer duration counts units of the selected time base.
// - At startup timer countdown loads from its duration setting.
// - Delay timers block the input until countdown reaches zero.
// - Extension timers hold output beyond input until countdown zero.
// - One-shot passes input until expiry, then waits for re-actuation.
// - Cell result on an input pin replaces that input downstream.
// - Inputs are plain high or low, never implicitly inverted.
// - Pins above 199 are internal links with no external function.
// - Ascending evaluation; same-cell feedback lands next tick.
// - Four each of AND, OR, XOR, latch, relay and timer cells.
// - Input pin is ten times port less one plus bit; outputs add 100.
`timescale 1ns/1ps
`default_nettype none
module user_gate_array
   import user_gate_array_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [IN_PINS-1:0] field_in_i,
   input wire logic [IN_PINS-1:0] ctrl_out_i,
   input wire cell_cfg_s [NUM_CELLS-1:0] cfg_i,
   output logic [IN_PINS-1:0] eff_in_o,
   output logic [IN_PINS-1:0] eff_out_o
);

   localparam int TICK_W = $clog2(TICK_LEN + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_CELLS - 1);
   localparam logic [TENTH_W-1:0] TENTH_LAST = TENTH_W'(TENTHS_PER_SEC - 1);
   localparam logic [PIN_W-1:0] FIRST_IN_PIN = pin_number(1, 0);

   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_EVAL, S_PUB} sweep_e;

   logic [IN_PINS-1:0] sync1_q;
   logic [IN_PINS-1:0] sync2_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick;
   logic [TENTH_W-1:0] tenth_q;
   logic sec_q;
   sweep_e state_q;
   logic [IDX_W-1:0] idx_q;
   logic [NUM_PINS-1:0] img_q;
   logic [CELLS_PER_KIND-1:0] latch_q;
   tmr_st_s [CELLS_PER_KIND-1:0] tmr_q;

   cell_cfg_s cfg;
   cell_kind_e kind;
   logic [1:0] sub;
   logic va;
   logic vb;
   logic ev_o1;
   logic ev_o2;
   logic latch_d;
   tmr_st_s tmr_d;

   // Field pins cross in through two flops; only the second is read
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (ce_i) begin
         sync1_q <= field_in_i;
         sync2_q <= sync1_q;
      end
   end

   // Tenth-second tick generator
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tick_cnt_q <= '0;
      end else if (ce_i) begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
      end
   end
   assign tick = (tick_cnt_q == TICK_LAST);

   // seconds prescaler: marks every tenth tick
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tenth_q <= '0;
         sec_q <= 1'b0;
      end else if (ce_i && tick) begin
         tenth_q <= (tenth_q == TENTH_LAST) ? '0 : tenth_q + TENTH_W'(1);
         sec_q <= (tenth_q == TENTH_LAST);
      end
   end

   // Sweep sequencer; one sweep per tick, far shorter than the tick
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         idx_q <= '0;
      end else if (ce_i) begin
         unique case (state_q)
            S_IDLE: begin
               if (tick) begin
                  state_q <= S_LOAD;
               end
            end
            S_LOAD: begin
               state_q <= S_EVAL;
               idx_q <= '0;
            end
            S_EVAL: begin
               if (idx_q == IDX_LAST) begin
                  state_q <= S_PUB;
               end else begin
                  idx_q <= idx_q + IDX_W'(1);
               end
            end
            S_PUB: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // four cells per kind, kinds in address order
   assign cfg = cfg_i[idx_q];
   assign kind = cell_kind_e'(idx_q[IDX_W-1:2]);
   assign sub = idx_q[1:0];

   // pins read as stored, no inversion
   assign va = img_q[cfg.a];
   assign vb = (kind == K_RELAY) ? img_q[cfg.d] : img_q[cfg.b];

   // shared evaluator decodes kind and timer type
   cell_eval u_eval (
      .kind_i(kind),
      .va_i(va),
      .vb_i(vb),
      .latch_q_i(latch_q[sub]),
      .tmr_i(tmr_q[sub]),
      .ttype_i(cfg.c),
      .ttime_i(cfg.d),
      .sec_i(sec_q),
      .o1_o(ev_o1),
      .o2_o(ev_o2),
      .latch_d_o(latch_d),
      .tmr_d_o(tmr_d)
   );

   // Pin image: load at sweep start, written by each cell in turn
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         img_q <= '0;
      end else if (ce_i) begin
         if (state_q == S_LOAD) begin
            // link pins keep last value, no field source
            img_q[IN_PINS-1:0] <= sync2_q;
            img_q[OUT_PIN_BASE +: IN_PINS] <= ctrl_out_i;
         end else if (state_q == S_EVAL) begin
            // later cells see this write in the same sweep
            unique case (kind)
               K_TIMER: begin
                  img_q[cfg.b] <= ev_o1;
               end
               K_RELAY: begin
                  img_q[cfg.b] <= ev_o1;
                  img_q[cfg.c] <= ev_o2;
               end
               default: begin
                  img_q[cfg.c] <= ev_o1;
                  img_q[cfg.d] <= ev_o2;
               end
            endcase
         end
      end
   end

   // latch startup state; update only during the sweep
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         latch_q <= {CELLS_PER_KIND{LATCH_RESET_STATE}};
      end else if (ce_i && state_q == S_EVAL && kind == K_LATCH) begin
         latch_q[sub] <= latch_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         for (int k = 0; k < CELLS_PER_KIND; k++) begin
            tmr_q[k].cnt <= cfg_i[TIMER_BASE + k].d;
            tmr_q[k].lock <= 1'b0;
         end
      end else if (ce_i && state_q == S_EVAL && kind == K_TIMER) begin
         tmr_q[sub] <= tmr_d;
      end
   end

   // results replace field values by pin number
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         eff_in_o <= '0;
         eff_out_o <= '0;
      end else if (ce_i && state_q == S_PUB) begin
         eff_in_o <= img_q[IN_PINS-1:0];
         eff_out_o <= img_q[OUT_PIN_BASE +: IN_PINS];
      end
   end

   // Checks below watch the evaluator and the sweep
   logic eval_now;
   assign eval_now = ce_i && (state_q == S_EVAL);

   sequence s_last_cell;
      eval_now && idx_q == IDX_LAST;
   endsequence

   sequence s_start;
      ce_i && state_q == S_LOAD;
   endsequence

   or_cell_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_OR |->
         ev_o1 == (va | vb) && ev_o2 == !(va | vb))
      else $error("OR cell output wrong");

   xor_cell_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_XOR |->
         ev_o1 == (va != vb) && ev_o2 == (va == vb))
      else $error("XOR cell output wrong");

   latch_init_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $past(rst_i) |-> latch_q == {CELLS_PER_KIND{1'b1}})
      else $error("latch not set after startup");

   latch_quiet_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !eval_now |=> $stable(latch_q))
      else $error("latch changed outside sweep");

   latch_clear_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_LATCH && vb |=>
         !latch_q[$past(sub)] && img_q[$past(cfg.d)])
      else $error("latch reset not honoured");

   latch_set_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_LATCH && va && !vb |=> latch_q[$past(sub)])
      else $error("latch set not honoured");

   relay_route_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_RELAY |->
         (vb ? (ev_o2 == va && !ev_o1) : (ev_o1 == va && !ev_o2)))
      else $error("relay routing wrong");

   delay_block_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_TIMER && tmr_q[sub].cnt != '0 &&
      (cfg.c == TT_DELAY_TENTH || cfg.c == TT_DELAY_SEC) |-> !ev_o1)
      else $error("delay timer passed early");

   sweep_order_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_start |=> state_q == S_EVAL && idx_q == '0 ##1 idx_q == IDX_W'(1))
      else $error("sweep did not start at cell zero");

   publish_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_last_cell ##1 ce_i |=> eff_in_o == $past(img_q[IN_PINS-1:0]))
      else $error("results not published after sweep");

   first_pin_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      state_q == S_LOAD && ce_i |=> img_q[FIRST_IN_PIN] == $past(sync2_q[0]))
      else $error("input pin numbering wrong");

   latch_pair_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_LATCH && cfg.c != cfg.d |=>
         img_q[$past(cfg.c)] != img_q[$past(cfg.d)])
      else $error("latch outputs not opposite");

   latch_hold_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_LATCH && !va && !vb |=>
         latch_q[$past(sub)] == $past(latch_q[sub]))
      else $error("latch changed with both inputs low");

   timer_load_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      $past(rst_i) |-> tmr_q[0].cnt == $past(cfg_i[TIMER_BASE].d) &&
         tmr_q[CELLS_PER_KIND-1].cnt ==
         $past(cfg_i[TIMER_BASE + CELLS_PER_KIND - 1].d))
      else $error("timer count not loaded at startup");

   ext_hold_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_TIMER && tmr_q[sub].cnt != '0 &&
      (cfg.c == TT_EXT_TENTH || cfg.c == TT_EXT_SEC) |-> ev_o1)
      else $error("extension timer dropped early");

   shot_lock_a: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      eval_now && kind == K_TIMER && tmr_q[sub].lock &&
      (cfg.c == TT_SHOT_TENTH || cfg.c == TT_SHOT_SEC) |-> !ev_o1)
      else $error("one-shot passed while locked");

endmodule // user_gate_array
`default_nettype wire

// >>> field_bits_model.sv
// Field input and controller output bits facing the gate array
`timescale 1ns/1ps
`default_nettype none
module field_bits_model
   import user_gate_array_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [IN_PINS-1:0] field_d_i,
   input wire logic [IN_PINS-1:0] ctrl_d_i,
   output logic [IN_PINS-1:0] field_o,
   output logic [IN_PINS-1:0] ctrl_o
);
   logic [IN_PINS-1:0] field_q = '0;
   logic [IN_PINS-1:0] ctrl_q = '0;

   // Levels move on the falling edge only, clear of the sampling edge
   always @(negedge mclk_i) begin
      field_q <= field_d_i;
      ctrl_q <= ctrl_d_i;
   end

   // Plain levels, no polarity change on the way in
   assign field_o = field_q;
   assign ctrl_o = ctrl_q;
endmodule // field_bits_model
`default_nettype wire

// >>> test_user_gate_array.sv
// Self-checking bench for the gate array with a reference sweep
`timescale 1ns/1ps
`default_nettype none
module test_user_gate_array
   import user_gate_array_pkg::*;
;
   localparam int TL = 40;
   localparam int STEPS = 150;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   int gap;
   logic [IN_PINS-1:0] fd = '0;
   logic [IN_PINS-1:0] cd = '0;
   wire logic [IN_PINS-1:0] fi;
   wire logic [IN_PINS-1:0] co;
   wire logic [IN_PINS-1:0] eff_in;
   wire logic [IN_PINS-1:0] eff_out;
   cell_cfg_s [NUM_CELLS-1:0] cfg;
   int n_errors = 0;
   int compares = 0;
   logic [199:0] exp_q[$];
   logic [255:0] img;
   logic [3:0] lq;
   logic [3:0] tl;
   logic [CNT_W-1:0] tc[4];
   int nsw;
   event chk;

   // Free running clock
   initial begin
      forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   field_bits_model far_u (.mclk_i(mclk), .field_d_i(fd), .ctrl_d_i(cd),
      .field_o(fi), .ctrl_o(co));

   // Short tick keeps the run small; every expectation follows TL
   user_gate_array #(.TICK_LEN(TL)) dut_u (.mclk_i(mclk), .rst_i(rst),
      .ce_i(ce), .field_in_i(fi), .ctrl_out_i(co), .cfg_i(cfg),
      .eff_in_o(eff_in), .eff_out_o(eff_out));

   function automatic cell_cfg_s cc(input int a, input int b,
                                    input int c, input int d);
      cc = '{PIN_W'(a), PIN_W'(b), PIN_W'(c), PIN_W'(d)};
   endfunction

   function automatic logic [IN_PINS-1:0] rbits();
      rbits = IN_PINS'({$urandom, $urandom, $urandom, $urandom});
   endfunction

   task automatic cmp_vec(input logic [IN_PINS-1:0] got,
                          input logic [IN_PINS-1:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Startup state: latches set, links low, timers loaded
   task automatic ref_reset();
      img = '0;
      lq = 4'hF;
      tl = 4'h0;
      nsw = 0;
      for (int k = 0; k < 4; k++) tc[k] = cfg[TIMER_BASE + k].d;
   endtask

   // One tick of the array, cells strictly in ascending order
   task automatic ref_sweep(input logic [IN_PINS-1:0] f,
                            input logic [IN_PINS-1:0] c);
      logic a;
      logic o;
      logic dec;
      int k;
      cell_cfg_s e;
      nsw++;
      img[99:0] = f;
      img[199:100] = c;
      for (int i = 0; i < NUM_CELLS; i++) begin
         e = cfg[i];
         a = img[e.a];
         k = i % 4;
         if (i < LATCH_BASE) begin
            o = (i < 4) ? (a & img[e.b]) : (i < 8) ? (a | img[e.b])
                : (a ^ img[e.b]);
            img[e.c] = o;
            img[e.d] = ~o;
         end else if (i < 16) begin
            // Reset wins over set, neither holds
            if (img[e.b]) lq[k] = 1'b0;
            else if (a) lq[k] = 1'b1;
            img[e.c] = lq[k];
            img[e.d] = ~lq[k];
         end else if (i < TIMER_BASE) begin
            o = img[e.d];
            img[e.b] = a & ~o;
            img[e.c] = a & o;
         end else begin
            // Whole-second types step on every tenth tick only
            dec = (e.c[7:4] == 4'h0) || (nsw % TENTHS_PER_SEC == 0);
            case (e.c)
               TT_DELAY_TENTH, TT_DELAY_SEC: begin
                  o = a && tc[k] == '0;
                  if (!a) tc[k] = e.d;
                  else if (dec && tc[k] != '0) tc[k]--;
               end
               TT_EXT_TENTH, TT_EXT_SEC: begin
                  o = a || tc[k] != '0;
                  if (a) tc[k] = e.d;
                  else if (dec && tc[k] != '0) tc[k]--;
               end
               TT_SHOT_TENTH, TT_SHOT_SEC: begin
                  o = a && !tl[k] && tc[k] != '0;
                  if (!a) begin
                     tc[k] = e.d;
                     tl[k] = 1'b0;
                  end else if (tc[k] == '0) begin
                     tl[k] = 1'b1;
                  end else if (dec && !tl[k]) begin
                     tc[k]--;
                  end
               end
               default: o = a;
            endcase
            img[e.b] = o;
         end
      end
   endtask

   // Reset, then one random step per tick; inputs land mid-tick
   task automatic run_phase();
      @(negedge mclk);
      rst <= 1'b1;
      repeat (8) @(negedge mclk);
      ref_reset();
      rst <= 1'b0;
      exp_q.push_back('0);
      repeat (33) @(negedge mclk);
      for (int s = 0; s <= STEPS; s++) begin
         ->chk;
         if (s == STEPS) break;
         // Sparse flips give long stretches for the timers
         fd = fd ^ (rbits() & rbits() & rbits());
         cd = cd ^ (rbits() & rbits());
         ref_sweep(fd, cd);
         exp_q.push_back({img[199:100], img[99:0]});
         // Short freezes in the idle gap; ticks count enabled cycles only
         gap = $urandom % 4;
         if (gap != 0) begin
            ce <= 1'b0;
            repeat (gap) @(negedge mclk);
            ce <= 1'b1;
         end
         repeat (TL) @(negedge mclk);
      end
   endtask

   // Oldest note against the published pin image
   always @(chk) begin
      logic [199:0] e;
      if (exp_q.size() == 0) begin
         n_errors++;
         $display("mismatch t=%0t no note got=%h exp=%h", $time, eff_in,
                  {IN_PINS{1'b0}});
      end else begin
         e = exp_q.pop_front();
         cmp_vec(eff_in, e[99:0]);
         cmp_vec(eff_out, e[199:100]);
      end
   end

   task automatic final_report();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Hang guard, well beyond both phases
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_errors++;
      final_report();
   end

   // Main sequence: gates, link chain, feedback, latch, relay, timers
   initial begin
      void'($urandom(32'hc1f8));
      for (int i = 0; i < NUM_CELLS; i++) cfg[i] = cc(250, 251, 252, 253);
      cfg[0] = cc(0, 1, 200, 251);
      cfg[4] = cc(200, 2, 10, 110);
      cfg[8] = cc(3, 105, 11, 111);
      cfg[9] = cc(30, 201, 201, 31);
      cfg[12] = cc(4, 5, 12, 112);
      cfg[16] = cc(6, 13, 14, 7);
      cfg[20] = cc(20, 21, TT_DELAY_TENTH, 3);
      cfg[21] = cc(22, 23, TT_EXT_TENTH, 2);
      cfg[22] = cc(24, 25, TT_SHOT_TENTH, 2);
      cfg[23] = cc(26, 27, TT_EXT_SEC, 1);
      run_phase();
      // Second phase: remaining whole-second codes, one unknown code
      cfg[20] = cc(20, 21, TT_DELAY_SEC, 1);
      cfg[21] = cc(22, 23, 8'h04, 2);
      cfg[22] = cc(24, 25, TT_SHOT_SEC, 1);
      run_phase();
      final_report();
   end
endmodule // test_user_gate_array
`default_nettype wire
